// ### logic/drs_pkg.sv
// Purpose: shared constants and types of the device reset sequencer
// Assumes: 50 MHz system clock, 32-bit register port with 8-bit address
// Notes:   all pin inputs travel together as one packed struct

`default_nettype none

package drs_pkg;

  // ==========================================================
  // sizes
  localparam int NCORE    = 4;
  localparam int CSEL_W   = 3;
  localparam int STRAP_W  = 13;
  localparam int PLLM_W   = 6;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 8;

  // core select code that hits every core
  localparam logic [CSEL_W-1:0] CSEL_ALL = 3'h7;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PLL     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DEVSTAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h0C;

  localparam int CTRL_SWRST_BIT = 0;
  localparam int CTRL_ISO_BIT   = 1;
  localparam int STAT_CCS_BIT   = 4;
  localparam int STAT_DDR_LSB   = 5;

  localparam logic [PLLM_W-1:0]  PLLM_RST    = 6'h10;
  localparam logic [STRAP_W-1:0] DEVSTAT_RST = 13'h0000;

  // ==========================================================
  // timing
  localparam int CLK_MHZ       = 50;
  localparam int INIT_TIME_NS  = 1000;
  localparam int SWRST_TIME_NS = 200;
  localparam int INIT_CYC  = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SWRST_CYC = (SWRST_TIME_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_COLD = 4'h1,
    ST_WARM = 4'h2,
    ST_INIT = 4'h4,
    ST_RUN  = 4'h8
  } drs_state_e;

  typedef struct packed {
    logic                 por_n;
    logic                 full_reset_n;
    logic                 warm_reset_n;
    logic                 core_local_reset_n;
    logic                 local_reset_nmi_strobe_n;
    logic                 nmi_n;
    logic [CSEL_W-1:0]    core_select;
    logic                 core_clock_select;
    logic [1:0]           ddr_slew_rate_select;
    logic [STRAP_W-1:0]   boot_strap_levels;
  } drs_pins_s;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [ADDR_W-1:0]    addr;
    logic [31:0]          wdata;
  } drs_bus_s;

endpackage

`default_nettype wire

// ### logic/drs_sequencer.sv
// Purpose: reset sequencing, strap capture and local core reset
// Assumes: board pins are asynchronous and pass two flip-flops first
// Notes:   emulation requests come from on-chip logic on the same clock

`timescale 1ns/100ps
`default_nettype none

// Contract
// (R1) full reset low acts as power-on, clears configuration, captures straps
// (R2) straps captured when full reset rises; pins then free for normal use
// (R3) controller holds full reset low through power-up and after power-on
// (R4) full reset may pulse any time after power-on; device returns to default
// (R5) controller keeps power-on and warm reset high before full reset release
// (R6) controller drives power-on and full reset as separate signals
// (R7) on bad supply controller asserts full reset with power-on reset
// (R8) warm reset from pin or register; spares test, emulation, isolated logic
// (R9) while warm reset low, three-state outputs float, others go inactive
// (R10) warm reset restores PLL settings unless reset isolation blocks it
// (R11) warm reset keeps previously latched or programmed strap values
// (R12) local reset hits only selected core or all cores
// (R13) local reset never drives reset status low
// (R14) controller sets select and local reset, pulses strobe, then holds
// (R15) select plus strobe with interrupt pin interrupts one chosen core; select code 7 interrupts all cores
// (R16) power management releases power-on only with stable supplies
// (R17) control logic reasserts full reset whenever power-on goes low
// (R18) controller holds warm reset high before power-on and full release
// (R19) warm reset held at power-up leaves device in warm-reset condition
// (R20) reset status low for nearly every source until initialization ends
// (R21) emulation hard or soft reset acts like that reset, never blocked
// (R22) clock select and slew select sampled continuously, never latched
// (R23) PLL multiplier set only by register writes, never by straps
// (R24) controller timing intervals are parameterised cycle counters
module drs_sequencer (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            srst,
  // board pins
  input  wire drs_pkg::drs_pins_s              pins,
  // on-chip emulation requests
  input  wire logic                            emu_hard_req,
  input  wire logic                            emu_soft_req,
  // register port
  input  wire drs_pkg::drs_bus_s               bus,
  output logic [31:0]                          rdata,
  // reset outputs
  output logic                                 reset_status_n,
  output logic                                 chip_reset_n,
  output logic                                 periph_reset_n,
  output logic                                 outputs_hiz,
  output logic [drs_pkg::NCORE-1:0]            core_reset_n,
  output logic [drs_pkg::NCORE-1:0]            core_nmi,
  // configuration outputs
  output logic [drs_pkg::PLLM_W-1:0]           pll_mult,
  output logic [drs_pkg::STRAP_W-1:0]          devstat,
  output logic                                 core_clock_select_q,
  output logic [1:0]                           ddr_slew_rate_select_q
);

  // ==========================================================
  // pin synchroniser
  // stage one is read only by stage two; edges use stages two and three
  drs_pkg::drs_pins_s s1_q;
  drs_pkg::drs_pins_s s2_q;
  drs_pkg::drs_pins_s s3_q;

  always_ff @(posedge clk) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  logic full_rise;
  logic strobe_fall;
  logic strobe_rise;

  always_comb begin
    full_rise   = s2_q.full_reset_n & ~s3_q.full_reset_n;
    strobe_fall = s3_q.local_reset_nmi_strobe_n
                  & ~s2_q.local_reset_nmi_strobe_n;
    strobe_rise = s2_q.local_reset_nmi_strobe_n
                  & ~s3_q.local_reset_nmi_strobe_n;
  end

  // ==========================================================
  // reset request decode
  logic                     cold_req;
  logic                     warm_req;
  logic [drs_pkg::CNT_W-1:0] swrst_cnt_q;

  always_comb begin
    cold_req = ~s2_q.por_n | ~s2_q.full_reset_n
               | emu_hard_req; // [R1] [R4] [R21]
    warm_req = ~s2_q.warm_reset_n | (swrst_cnt_q != '0)
               | emu_soft_req;                                  // [R8] [R21]
  end

  // ==========================================================
  // sequencing state machine
  drs_pkg::drs_state_e       state_q;
  drs_pkg::drs_state_e       state_d;
  logic [drs_pkg::CNT_W-1:0] init_cnt_q;
  logic [drs_pkg::CNT_W-1:0] init_cnt_d;

  always_comb begin
    state_d    = state_q;
    init_cnt_d = init_cnt_q;
    case (state_q)
      drs_pkg::ST_COLD: begin
        init_cnt_d = drs_pkg::CNT_W'(drs_pkg::INIT_CYC);
        if (cold_req) begin
          state_d = drs_pkg::ST_COLD;
        end else if (warm_req) begin
          state_d = drs_pkg::ST_WARM;                           // [R19]
        end else begin
          state_d = drs_pkg::ST_INIT;
        end
      end
      drs_pkg::ST_WARM: begin
        init_cnt_d = drs_pkg::CNT_W'(drs_pkg::INIT_CYC);
        if (cold_req) begin
          state_d = drs_pkg::ST_COLD;
        end else if (!warm_req) begin
          state_d = drs_pkg::ST_INIT;
        end
      end
      drs_pkg::ST_INIT: begin
        if (cold_req) begin
          state_d = drs_pkg::ST_COLD;
        end else if (warm_req) begin
          state_d = drs_pkg::ST_WARM;
        end else if (init_cnt_q <= drs_pkg::CNT_W'(1)) begin
          state_d = drs_pkg::ST_RUN;                            // [R20]
        end else begin
          init_cnt_d = init_cnt_q - drs_pkg::CNT_W'(1);
        end
      end
      drs_pkg::ST_RUN: begin
        if (cold_req) begin
          state_d = drs_pkg::ST_COLD;
        end else if (warm_req) begin
          state_d = drs_pkg::ST_WARM;
        end
      end
      default: begin
        state_d = drs_pkg::ST_COLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= drs_pkg::ST_COLD;
      init_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  logic in_cold;
  logic in_reset;

  always_comb begin
    in_cold  = (state_q == drs_pkg::ST_COLD);
    in_reset = in_cold | (state_q == drs_pkg::ST_WARM);
  end

  // ==========================================================
  // configuration registers
  logic                        iso_q;
  logic                        iso_d;
  logic [drs_pkg::PLLM_W-1:0]  pllm_q;
  logic [drs_pkg::PLLM_W-1:0]  pllm_d;
  logic [drs_pkg::STRAP_W-1:0] devstat_q;
  logic [drs_pkg::STRAP_W-1:0] devstat_d;
  logic [drs_pkg::CNT_W-1:0]   swrst_cnt_d;
  logic                        wr_ctrl;
  logic                        wr_pll;
  logic                        wr_dev;

  always_comb begin
    wr_ctrl     = bus.wr & (bus.addr == drs_pkg::ADDR_CTRL);
    wr_pll      = bus.wr & (bus.addr == drs_pkg::ADDR_PLL);
    wr_dev      = bus.wr & (bus.addr == drs_pkg::ADDR_DEVSTAT);
    iso_d       = iso_q;
    pllm_d      = pllm_q;
    devstat_d   = devstat_q;
    swrst_cnt_d = swrst_cnt_q;
    if (swrst_cnt_q != '0) begin
      swrst_cnt_d = swrst_cnt_q - drs_pkg::CNT_W'(1);
    end
    if (in_cold) begin
      // full and power-on reset clear isolation, PLL multiplier and software reset count; straps are not cleared here
      iso_d       = 1'b0;                                       // [R1]
      pllm_d      = drs_pkg::PLLM_RST;
      swrst_cnt_d = '0;
    end else begin
      if (in_reset && !iso_q) begin
        pllm_d = drs_pkg::PLLM_RST;                             // [R10]
      end else if (wr_pll) begin
        pllm_d = bus.wdata[drs_pkg::PLLM_W-1:0];                // [R23]
      end
      if (wr_ctrl) begin
        iso_d = bus.wdata[drs_pkg::CTRL_ISO_BIT];
        if (bus.wdata[drs_pkg::CTRL_SWRST_BIT]) begin
          swrst_cnt_d = drs_pkg::CNT_W'(drs_pkg::SWRST_CYC);    // [R8]
        end
      end
      if (wr_dev) begin
        devstat_d = bus.wdata[drs_pkg::STRAP_W-1:0];
      end
    end
    // warm reset never touches the latched straps
    if (full_rise && s2_q.por_n) begin
      devstat_d = s2_q.boot_strap_levels;                       // [R2] [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      iso_q       <= 1'b0;
      pllm_q      <= drs_pkg::PLLM_RST;
      devstat_q   <= drs_pkg::DEVSTAT_RST;
      swrst_cnt_q <= '0;
    end else begin
      iso_q       <= iso_d;
      pllm_q      <= pllm_d;
      devstat_q   <= devstat_d;
      swrst_cnt_q <= swrst_cnt_d;
    end
  end

  // ==========================================================
  // local core reset and interrupt
  // the select code is held from the strobe fall, so a late select
  // change during the pulse cannot move the reset to another core
  logic                      lrst_q;
  logic                      lrst_d;
  logic [drs_pkg::CSEL_W-1:0] sel_q;
  logic [drs_pkg::CSEL_W-1:0] sel_d;
  logic                      nmi_go;

  always_comb begin
    lrst_d = lrst_q;
    sel_d  = sel_q;
    nmi_go = 1'b0;
    if (strobe_fall) begin
      sel_d = s2_q.core_select;
      if (!s2_q.core_local_reset_n) begin
        lrst_d = 1'b1;                                          // [R12]
      end else if (!s2_q.nmi_n) begin
        nmi_go = 1'b1;                                          // [R15]
      end
    end else if (strobe_rise) begin
      lrst_d = 1'b0;
    end
    if (in_cold) begin
      lrst_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lrst_q <= 1'b0;
      sel_q  <= '0;
    end else begin
      lrst_q <= lrst_d;
      sel_q  <= sel_d;
    end
  end

  logic [drs_pkg::NCORE-1:0] core_rst_n_d;
  logic [drs_pkg::NCORE-1:0] nmi_d;

  genvar gi;
  generate
    for (gi = 0; gi < drs_pkg::NCORE; gi++) begin : g_core
      logic hit_now;
      logic hit_held;
      always_comb begin
        hit_now  = (s2_q.core_select == drs_pkg::CSEL_W'(gi))
                   | (s2_q.core_select == drs_pkg::CSEL_ALL);
        hit_held = (sel_q == drs_pkg::CSEL_W'(gi))
                   | (sel_q == drs_pkg::CSEL_ALL);
        core_rst_n_d[gi] = !in_reset && !(lrst_q && hit_held); // [R12]
        nmi_d[gi]        = nmi_go && hit_now && !in_reset;      // [R15]
      end
    end
  endgenerate

  // ==========================================================
  // registered outputs and read port
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (bus.rd) begin
      case (bus.addr)
        drs_pkg::ADDR_CTRL: begin
          rdata_d[drs_pkg::CTRL_SWRST_BIT] = (swrst_cnt_q != '0);
          rdata_d[drs_pkg::CTRL_ISO_BIT]   = iso_q;
        end
        drs_pkg::ADDR_PLL: begin
          rdata_d[drs_pkg::PLLM_W-1:0] = pllm_q;
        end
        drs_pkg::ADDR_DEVSTAT: begin
          rdata_d[drs_pkg::STRAP_W-1:0] = devstat_q;
        end
        drs_pkg::ADDR_STATUS: begin
          rdata_d[3:0] = state_q;
          rdata_d[drs_pkg::STAT_CCS_BIT] = s2_q.core_clock_select;
          rdata_d[drs_pkg::STAT_DDR_LSB +: 2] =
            s2_q.ddr_slew_rate_select;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata                  <= '0;
      reset_status_n         <= 1'b0;
      chip_reset_n           <= 1'b0;
      periph_reset_n         <= 1'b0;
      outputs_hiz            <= 1'b1;
      core_reset_n           <= '0;
      core_nmi               <= '0;
      pll_mult               <= drs_pkg::PLLM_RST;
      devstat                <= drs_pkg::DEVSTAT_RST;
      core_clock_select_q    <= 1'b0;
      ddr_slew_rate_select_q <= 2'h0;
    end else begin
      rdata                  <= rdata_d;
      // local reset is not a term here, so status stays high for it
      reset_status_n         <= (state_q == drs_pkg::ST_RUN); // [R13] [R20]
      chip_reset_n           <= !in_cold;                      // [R1]
      periph_reset_n         <= !in_reset;                     // [R8]
      outputs_hiz            <= in_reset;                      // [R9]
      core_reset_n           <= core_rst_n_d;
      core_nmi               <= nmi_d;
      pll_mult               <= pllm_q;
      devstat                <= devstat_q;
      core_clock_select_q    <= s2_q.core_clock_select;        // [R22]
      ddr_slew_rate_select_q <= s2_q.ddr_slew_rate_select;     // [R22]
    end
  end

endmodule

`default_nettype wire

// ### tb/drs_sequencer_assertions.sv
// Purpose: port checks of the reset sequencer
// Assumes: one clock, srst synchronous
// Notes:   pin checks leave slack for the input syncs
`timescale 1ns/100ps
`default_nettype none
module drs_sequencer_assertions (
  // clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // inputs
  input wire drs_pkg::drs_pins_s pins,
  input wire logic               emu_hard_req,
  input wire logic               emu_soft_req,
  input wire drs_pkg::drs_bus_s  bus,
  // outputs
  input wire logic [31:0]        rdata,
  input wire logic               reset_status_n,
  input wire logic               chip_reset_n,
  input wire logic               periph_reset_n,
  input wire logic               outputs_hiz,
  input wire logic [3:0]         core_reset_n,
  input wire logic [3:0]         core_nmi,
  input wire logic [5:0]         pll_mult,
  input wire logic [12:0]        devstat,
  input wire logic               core_clock_select_q,
  input wire logic [1:0]         ddr_slew_rate_select_q
);
  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_hiz_in_reset: assert property (!periph_reset_n |-> outputs_hiz)
    else $error("outputs driven during reset");
  a_warm_pin_reset: assert property (!pins.warm_reset_n [*6] |->
    outputs_hiz && !periph_reset_n && chip_reset_n)
    else $error("warm pin did not reset");
  a_full_pin_cold: assert property (!pins.full_reset_n [*6] |->
    !chip_reset_n && !reset_status_n)
    else $error("full reset pin did not reset");
  a_status_cause: assert property ($fell(reset_status_n) |->
    !periph_reset_n)
    else $error("status fell without device reset");
  a_status_held: assert property (!periph_reset_n |-> !reset_status_n)
    else $error("status high during reset");
  a_init_span: assert property ($rose(reset_status_n) |->
    $past(periph_reset_n, 49))
    else $error("initialization too short");
  a_local_single: assert property (periph_reset_n |->
    $onehot0(~core_reset_n) || core_reset_n == 4'h0)
    else $error("local reset hit wrong cores");
  a_nmi_target: assert property (core_nmi != 4'h0 |-> periph_reset_n &&
    ($onehot(core_nmi) || core_nmi == 4'hF))
    else $error("interrupt to wrong cores");
  a_pll_bus_only: assert property ($changed(pll_mult) |->
    ($past(bus.wr, 2) && $past(bus.addr, 2) == drs_pkg::ADDR_PLL) ||
    !periph_reset_n || !$past(periph_reset_n))
    else $error("multiplier changed without write");
  a_devstat_kept: assert property ($changed(devstat) &&
    $past(chip_reset_n, 3) |->
    $past(bus.wr, 2) && $past(bus.addr, 2) == drs_pkg::ADDR_DEVSTAT)
    else $error("strap register changed");
  a_cfg_live: assert property (($stable(pins.core_clock_select) &&
    $stable(pins.ddr_slew_rate_select)) [*4] |->
    core_clock_select_q == pins.core_clock_select &&
    ddr_slew_rate_select_q == pins.ddr_slew_rate_select)
    else $error("config pins not followed");

  c_local: cover property ($fell(core_reset_n[1]) && periph_reset_n);
  c_nmi: cover property (core_nmi != 4'h0);
  c_warm: cover property ($fell(periph_reset_n) && chip_reset_n);
endmodule

bind drs_sequencer drs_sequencer_assertions u_chk (
  .clk(clk), .srst(srst), .pins(pins), .emu_hard_req(emu_hard_req),
  .emu_soft_req(emu_soft_req), .bus(bus), .rdata(rdata),
  .reset_status_n(reset_status_n), .chip_reset_n(chip_reset_n),
  .periph_reset_n(periph_reset_n), .outputs_hiz(outputs_hiz),
  .core_reset_n(core_reset_n), .core_nmi(core_nmi), .pll_mult(pll_mult),
  .devstat(devstat), .core_clock_select_q(core_clock_select_q),
  .ddr_slew_rate_select_q(ddr_slew_rate_select_q));
`default_nettype wire

// ### tb/drs_board_model.sv
// Purpose: board power and reset controller driving the device pins
// Assumes: pins change just after a rising edge
// Notes:   released strap lines show the inverse of their last level
`timescale 1ns/100ps
`default_nettype none
module drs_board_model #(
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 6,
  parameter int HOLD_CYC  = 2,
  parameter int FULL_DLY  = 8
) (
  // clock
  input wire logic               clk,
  // device pins
  output var drs_pkg::drs_pins_s pins
);
  // warm stays high from the start so the device never wakes in warm reset
  initial begin
    pins = '1;
    pins.por_n = 1'b0;
    pins.full_reset_n = 1'b0;
  end
  task automatic power_up(input logic [12:0] s);
    pins.boot_strap_levels <= s;
    repeat (5) @(posedge clk);
    pins.por_n <= 1'b1;
    full_release(s);
  endtask
  task automatic full_release(input logic [12:0] s);
    repeat (FULL_DLY) @(posedge clk);
    pins.full_reset_n <= 1'b1;
    repeat (HOLD_CYC) @(posedge clk);
    pins.boot_strap_levels <= ~s;
  endtask
  task automatic full_pulse(input logic [12:0] s);
    pins.full_reset_n <= 1'b0;
    pins.boot_strap_levels <= s;
    full_release(s);
  endtask
  task automatic warm_pulse(input int n);
    @(posedge clk);
    pins.warm_reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    pins.warm_reset_n <= 1'b1;
  endtask
  task automatic sel_start(input logic [2:0] sel, input logic nmi);
    @(posedge clk);
    pins.core_select <= sel;
    if (nmi) pins.nmi_n <= 1'b0;
    else pins.core_local_reset_n <= 1'b0;
    repeat (SETUP_CYC) @(posedge clk);
    pins.local_reset_nmi_strobe_n <= 1'b0;
    repeat (PULSE_CYC) @(posedge clk);
  endtask
  task automatic sel_end();
    pins.local_reset_nmi_strobe_n <= 1'b1;
    repeat (HOLD_CYC) @(posedge clk);
    pins.core_local_reset_n <= 1'b1;
    pins.nmi_n <= 1'b1;
  endtask
  task automatic set_cfg(input logic c, input logic [1:0] d);
    @(posedge clk);
    pins.core_clock_select <= c;
    pins.ddr_slew_rate_select <= d;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_drs_sequencer.sv
// Purpose: self-checking bench of the reset sequencer
// Assumes: 50 MHz clock, board model drives all pins
// Notes:   outputs are sampled on the falling edge or just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module tb_drs_sequencer;
  logic               clk;
  logic               srst;
  logic               emu_hard_req;
  logic               emu_soft_req;
  drs_pkg::drs_bus_s  bus;
  drs_pkg::drs_pins_s pins;
  logic [31:0]        rdata;
  logic               reset_status_n;
  logic               chip_reset_n;
  logic               periph_reset_n;
  logic               outputs_hiz;
  logic [3:0]         core_reset_n;
  logic [3:0]         core_nmi;
  logic [5:0]         pll_mult;
  logic [12:0]        devstat;
  logic               ccs_q;
  logic [1:0]         ddr_q;
  logic [3:0]         nmi_seen;
  int                 nmi_cnt;
  int                 fail_count;
  int                 total_checks;

  drs_board_model u_board (.clk(clk), .pins(pins));
  drs_sequencer DUT (
    .clk(clk), .srst(srst), .pins(pins), .emu_hard_req(emu_hard_req),
    .emu_soft_req(emu_soft_req), .bus(bus), .rdata(rdata),
    .reset_status_n(reset_status_n), .chip_reset_n(chip_reset_n),
    .periph_reset_n(periph_reset_n), .outputs_hiz(outputs_hiz),
    .core_reset_n(core_reset_n), .core_nmi(core_nmi),
    .pll_mult(pll_mult), .devstat(devstat),
    .core_clock_select_q(ccs_q), .ddr_slew_rate_select_q(ddr_q));

  // ==========================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (core_nmi !== 4'h0) begin
      nmi_seen = nmi_seen | core_nmi;
      nmi_cnt++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (reset_status_n !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(32'(reset_status_n), 32'h1);
    @(posedge clk);
  endtask
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_power_regs();
    u_board.power_up(13'h1A5C);
    wait_run();
    chk(32'(devstat), 32'h1A5C);
    chk(32'(pll_mult), 32'(drs_pkg::PLLM_RST));
    rd(drs_pkg::ADDR_STATUS, 32'h78);
    wr(drs_pkg::ADDR_PLL, 32'h22);
    wr(drs_pkg::ADDR_DEVSTAT, 32'h0F0F);
    wr(8'h10, 32'h3F);
    rd(drs_pkg::ADDR_PLL, 32'h22);
    rd(8'h10, 32'h0);
    chk(32'(devstat), 32'h0F0F);
    rd(drs_pkg::ADDR_DEVSTAT, 32'h0F0F);
  endtask
  task automatic t_warm();
    u_board.warm_pulse(8);
    @(negedge clk);
    chk({outputs_hiz, periph_reset_n, chip_reset_n}, 32'h5);
    wait_run();
    chk(32'(pll_mult), 32'(drs_pkg::PLLM_RST));
    chk(32'(devstat), 32'h0F0F);
    wr(drs_pkg::ADDR_PLL, 32'h22);
    wr(drs_pkg::ADDR_CTRL, 32'h3);
    repeat (4) @(negedge clk);
    chk(32'(periph_reset_n), 32'h0);
    wait_run();
    chk(32'(pll_mult), 32'h22);
    rd(drs_pkg::ADDR_CTRL, 32'h2);
  endtask
  task automatic t_local(input logic [2:0] sel, input logic [3:0] exp);
    u_board.sel_start(sel, 1'b0);
    chk(32'(core_reset_n), 32'(exp));
    chk({reset_status_n, periph_reset_n}, 32'h3);
    u_board.sel_end();
    repeat (6) @(negedge clk);
    chk(32'(core_reset_n), 32'hF);
  endtask
  task automatic t_nmi();
    nmi_seen = 4'h0;
    nmi_cnt = 0;
    u_board.sel_start(3'h2, 1'b1);
    u_board.sel_end();
    chk({nmi_seen, 4'(nmi_cnt), core_reset_n}, 32'h41F);
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      u_board.set_cfg(~i[0], 2'(i));
      repeat (5) @(negedge clk);
      chk({ccs_q, ddr_q}, {29'h0, ~i[0], 2'(i)});
      rd(drs_pkg::ADDR_STATUS, {25'h0, 2'(i), ~i[0], 4'h8});
    end
  endtask
  task automatic t_emu();
    wr(drs_pkg::ADDR_CTRL, 32'h0);
    emu_soft_req <= 1'b1;
    @(posedge clk);
    emu_soft_req <= 1'b0;
    repeat (2) @(negedge clk);
    chk({periph_reset_n, chip_reset_n}, 32'h1);
    wait_run();
    chk(32'(devstat), 32'h0F0F);
    wr(drs_pkg::ADDR_PLL, 32'h15);
    emu_hard_req <= 1'b1;
    @(posedge clk);
    emu_hard_req <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(chip_reset_n), 32'h0);
    wait_run();
    chk(32'(pll_mult), 32'(drs_pkg::PLLM_RST));
    u_board.full_pulse(13'h0123);
    wait_run();
    chk(32'(devstat), 32'h0123);
  endtask

  initial begin
    srst = 1'b1;
    emu_hard_req = 1'b0;
    emu_soft_req = 1'b0;
    bus = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_power_regs();
    t_warm();
    t_local(3'h1, 4'hD);
    t_local(drs_pkg::CSEL_ALL, 4'h0);
    t_nmi();
    t_cfg();
    t_emu();
    final_report();
  end
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
